// ### bench/analog_core_model.sv
// Behavioural analog core: gives the level of the selected input.
// Assumes the bench holds pin_level steady over each conversion.
`timescale 1ns/10ps
module analog_core_model (
  // Clock
  input  wire logic       hclk,
  // Selection from the block
  input  wire logic [7:0] analog_inputs,
  input  wire logic       ref_high,
  input  wire logic       ref_low,
  input  wire logic       conv_busy,
  // Level on the driven pin
  input  wire logic [9:0] pin_level,
  // Result to the block
  output logic      [9:0] conv_data
);
  logic [9:0] junk_r = 10'h155;

  // Junk moves every cycle so an unselected sample never matches by luck
  always @(posedge hclk) junk_r <= ~junk_r ^ 10'h2a5;

  always_comb begin
    if (!conv_busy)
      conv_data = junk_r;
    else if (ref_high)
      conv_data = 10'h3ff;
    else if (ref_low)
      conv_data = 10'h000;
    else if (|analog_inputs)
      conv_data = pin_level;
    else
      conv_data = junk_r;
  end
endmodule // analog_core_model

// ### bench/testbench.sv
// Self-checking bench of the converter control block over AHB-Lite.
// Assumes zero-wait-state answers and the analog core model beside it.
`timescale 1ns/10ps
module testbench;
  import adc_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hready, hreadyout, hresp, crystal_osc_clock = 1'b0;
  logic [9:0]  conv_data, pin_level = 10'h0, v;
  logic        conv_tick, conv_busy, conv_done, ref_high, ref_low;
  logic        converter_power_off, conv_irq, busy_q = 1'b0, rd_dp = 1'b0;
  logic [4:0]  channel_select;
  logic [7:0]  analog_inputs, cfg;
  logic [2:0]  ch;
  logic [31:0] exp_q[$];
  int          n_mismatch = 0, check_count = 0, seed = 3, dv, t0;
  int          tick_cnt = 0, busy_cnt = 0, tick_all = 0;

  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  always @(posedge hclk) crystal_osc_clock <= ~crystal_osc_clock;

  adc_register_control DUT (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp,
    .crystal_osc_clock, .conv_data, .conv_tick, .conv_busy, .conv_done,
    .channel_select, .analog_inputs, .ref_high, .ref_low,
    .converter_power_off, .conv_irq);

  analog_core_model core (.hclk, .analog_inputs, .ref_high, .ref_low,
    .conv_busy, .pin_level, .conv_data);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  // Read data is compared in the data phase, oldest note first
  always @(posedge hclk) begin
    if (rd_dp && hready) begin
      check_count++;
      if (exp_q.size() == 0 || hrdata !== exp_q[0] || hresp !== HRESP_OKAY) begin
        $display("Error at %0t: read data %h", $time, hrdata);
        n_mismatch++;
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
    if (hready) rd_dp <= hsel && htrans[1] && !hwrite;
  end

  // Conversion length counters, restarted when busy rises
  always @(posedge hclk) begin
    busy_q <= conv_busy;
    tick_all <= tick_all + 32'(conv_tick);
    if (conv_busy && !busy_q) begin
      tick_cnt <= 32'(conv_tick);
      busy_cnt <= 1;
    end else if (conv_busy) begin
      tick_cnt <= tick_cnt + 32'(conv_tick);
      busy_cnt <= busy_cnt + 1;
    end
  end

  task automatic ahb(input logic [7:0] a, input logic wr,
                     input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    ahb(a, 1'b0, 8'h0);
  endtask

  function automatic logic [31:0] hi_of(input logic [9:0] x,
                                        input logic [1:0] m);
    case (m)
      2'b00:   hi_of = 32'h0;
      2'b01:   hi_of = {30'h0, x[9:8]};
      2'b10:   hi_of = {24'h0, x[9:2]};
      default: hi_of = {24'h0, ~x[9], x[8:2]};
    endcase
  endfunction

  function automatic logic [31:0] lo_of(input logic [9:0] x,
                                        input logic [1:0] m);
    case (m)
      2'b00:   lo_of = {24'h0, x[9:2]};
      2'b01:   lo_of = {24'h0, x[7:0]};
      default: lo_of = {24'h0, x[1:0], 6'h0};
    endcase
  endfunction

  task automatic rd_res(input logic [9:0] x, input logic [1:0] m);
    rd(OFS_RESH, hi_of(x, m));
    rd(OFS_RESL, lo_of(x, m));
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (conv_done !== 1'b1 && n < 1000);
    chk(32'(n < 1000), 32'h1);
  endtask

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(32'(converter_power_off), 32'h1);
    rd(OFS_CTRL, 32'h1f);
    rd(OFS_CLKCFG, 32'h04);
    rd(8'h50, 32'h0);
    ahb(8'h50, 1'b1, 8'hff);
    rd(8'h50, 32'h0);
    // Power up on the crystal source; settling costs one conversion
    v = 10'($random(seed));
    pin_level <= v;
    t0 = tick_all;
    ahb(OFS_CTRL, 1'b1, 8'h00);
    @(posedge hclk);
    chk(32'(converter_power_off), 32'h0);
    wait_done();
    chk(32'(tick_all - t0 >= 34), 32'h1);
    chk(32'(busy_cnt >= 64), 32'h1);
    rd_res(v, 2'b01);
    // Every divider step and every justify mode, bus clock source
    for (int i = 0; i < 5; i++) begin
      dv = 1 << i;
      cfg = {(i == 4) ? 3'h7 : 3'(i), 1'b1, 2'(i), 2'b00};
      ahb(OFS_CLKCFG, 1'b1, cfg);
      rd(OFS_CLKCFG, {24'h0, cfg});
      v = 10'($random(seed));
      ch = 3'($random(seed));
      pin_level <= v;
      ahb(OFS_CTRL, 1'b1, {5'h0, ch});
      @(posedge hclk);
      chk({24'h0, analog_inputs}, 32'h1 << ch);
      chk({27'h0, channel_select}, {29'h0, ch});
      wait_done();
      chk(32'(tick_cnt), 32'd17);
      chk(32'(busy_cnt >= 16 * dv && busy_cnt <= 17 * dv + 1), 32'h1);
      rd(OFS_CTRL, {24'h0, 5'h10, ch});
      rd_res(v, 2'(i));
      rd(OFS_CTRL, {29'h0, ch});
      chk(32'(conv_busy), 32'h0);
    end
    // Continuous mode with the high/low interlock
    ahb(OFS_CLKCFG, 1'b1, 8'h14);
    ahb(OFS_CTRL, 1'b1, {5'h4, ch});
    wait_done();
    rd(OFS_RESH, hi_of(v, 2'b01));
    pin_level <= ~v;
    repeat (40) @(posedge hclk);
    rd(OFS_RESL, lo_of(v, 2'b01));
    wait_done();
    rd_res(~v, 2'b01);
    repeat (20) @(posedge hclk);
    rd(OFS_CTRL, {24'h0, 5'h04, ch});
    // Interrupt request raised, cleared by write and by read
    ahb(OFS_CTRL, 1'b1, {5'h8, ch});
    wait_done();
    chk(32'(conv_irq), 32'h1);
    rd(OFS_CTRL, {24'h0, 5'h18, ch});
    ahb(OFS_CTRL, 1'b1, {5'h8, ch});
    @(posedge hclk);
    chk(32'(conv_irq), 32'h0);
    wait_done();
    rd(OFS_RESL, lo_of(~v, 2'b01));
    @(posedge hclk);
    chk(32'(conv_irq), 32'h0);
    ahb(OFS_CTRL, 1'b1, {5'h18, ch});
    @(posedge hclk);
    chk(32'(conv_irq), 32'h1);
    // Abort into the reference channels
    ahb(OFS_CTRL, 1'b1, 8'h00);
    repeat (5) @(posedge hclk);
    ahb(OFS_CTRL, 1'b1, {3'h0, CHAN_REFH});
    @(posedge hclk);
    chk(32'(ref_high), 32'h1);
    wait_done();
    chk(32'(busy_cnt > 17), 32'h1);
    rd_res(10'h3ff, 2'b01);
    ahb(OFS_CTRL, 1'b1, {3'h0, CHAN_REFL});
    @(posedge hclk);
    chk(32'(ref_low & ~ref_high), 32'h1);
    wait_done();
    rd_res(10'h000, 2'b01);
    ahb(OFS_CTRL, 1'b1, 8'h1f);
    repeat (30) @(posedge hclk);
    chk({31'h0, converter_power_off & ~conv_busy}, 32'h1);
    give_verdict();
  end
endmodule // testbench

// ### rtl/adc_pkg.sv
// Constants, field layout and types of the converter control block.
// Assumes an AHB-Lite slave with 32-bit data and a 100 MHz hclk.
//
// Notes on behaviour
// [R1] Without irq enable, complete flag is read-only; continuous mode sets it once.
// [R2] Control/status write or result read clears the complete flag.
// [R3] With irq enable, flag is writable and software clears it; reset clears.
// [R4] Irq enable raises request per conversion; read or control write drops it.
// [R5] Continuous bit converts repeatedly; otherwise one conversion per control write.
// [R6] Channel codes 0-7 pick analog inputs; 1d high reference, 1e low.
// [R7] Channel code all ones powers the converter off; reset value.
// [R8] First conversion after leaving power-off only stabilises, result discarded.
// [R9] Unused channel codes give undefined conversion results.
// [R10] Left mode: high holds eight top bits, low two bottom bits.
// [R11] Right mode: high holds two top bits, low eight bottom bits.
// [R12] Left signed mode is left mode with the top result bit inverted.
// [R13] Both result registers update at every completed conversion.
// [R14] In 10-bit modes reading high freezes results until low is read.
// [R15] Truncation mode: low holds eight top bits, high reads zero, no lock.
// [R16] Three-bit divider code: 1, 2, 4, 8, or 16 when top bit set.
// [R17] Input clock select: 1 bus clock, 0 crystal clock; reset crystal.
// [R18] Justify field: 00 trunc, 01 right, 10 left, 11 signed; reset right.
// [R19] Software keeps the converter clock near 1 MHz.
// [R20] Conversion starts on control write and lasts 17 converter clocks.
// [R21] Continuous results overwrite earlier ones whether read or not.
// [R22] Control write during a conversion aborts it and restarts with new settings.
package adc_pkg;

  // Byte offsets of the registers
  localparam logic [7:0] OFS_CTRL   = 8'h3c;
  localparam logic [7:0] OFS_RESH   = 8'h40;
  localparam logic [7:0] OFS_RESL   = 8'h44;
  localparam logic [7:0] OFS_CLKCFG = 8'h48;

  // Control/status fields
  localparam int CS_FLAG_BIT  = 7;
  localparam int CS_IRQEN_BIT = 6;
  localparam int CS_CONT_BIT  = 5;
  localparam int CS_CHAN_MSB  = 4;

  // Clock configuration fields
  localparam int CK_DIV_LSB  = 5;
  localparam int CK_SRC_BIT  = 4;
  localparam int CK_JUST_LSB = 2;

  localparam logic [7:0] CTRL_RESET   = 8'h1f;
  localparam logic [7:0] CLKCFG_RESET = 8'h04;

  localparam logic [4:0] CHAN_OFF  = 5'h1f;
  localparam logic [4:0] CHAN_REFH = 5'h1d;
  localparam logic [4:0] CHAN_REFL = 5'h1e;
  localparam logic [4:0] CHAN_PINS = 5'h08;

  // Converter clocks per conversion, upper end of 16 to 17
  localparam logic [4:0] CONV_CYCLES = 5'h11;
  localparam logic [2:0] DIV_MAX_LOG = 3'h4;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  typedef enum logic [1:0] {
    JUST_TRUNC8 = 2'b00,
    JUST_RIGHT  = 2'b01,
    JUST_LEFT   = 2'b10,
    JUST_SIGNED = 2'b11
  } justify_t;

  typedef enum logic [2:0] {
    REG_NONE = 3'b000,
    REG_CTRL = 3'b001,
    REG_RESH = 3'b010,
    REG_RESL = 3'b011,
    REG_CLK  = 3'b100
  } reg_id_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01
  } conv_state_t;

endpackage

// ### rtl/adc_register_control.sv
// Register file, conversion sequencing and result formatting of the ADC.
// Assumes a single AHB-Lite master, an analog core that presents its
// 10-bit result on conv_data in the cycle before conv_done pulses, and a crystal clock
// that is already synchronous to hclk.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/10ps
module adc_register_control
  import adc_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Clock source
  input  wire logic        crystal_osc_clock,
  // Analog core
  input  wire logic [9:0]  conv_data,
  output logic             conv_tick,
  output logic             conv_busy,
  output logic             conv_done,
  output logic [4:0]       channel_select,
  output logic [7:0]       analog_inputs,
  output logic             ref_high,
  output logic             ref_low,
  output logic             converter_power_off,
  // Interrupt request
  output logic             conv_irq
);
  import adc_pkg::*;

  function automatic reg_id_t decode(input logic [7:0] a);
    case (a)
      OFS_CTRL:   decode = REG_CTRL;
      OFS_RESH:   decode = REG_RESH;
      OFS_RESL:   decode = REG_RESL;
      OFS_CLKCFG: decode = REG_CLK;
      default:    decode = REG_NONE;
    endcase
  endfunction

  // Bus side
  logic        acc;
  logic        rd_acc;
  logic        wr_pend_r;
  reg_id_t     wr_id_r;
  reg_id_t     acc_id;
  logic        wr_ctrl;
  logic        wr_clk;
  logic        rd_high;
  logic        rd_low;
  logic [31:0] rdata_nxt;
  logic [31:0] hrdata_r;

  // Register state
  logic        flag_r;
  logic        irq_en_r;
  logic        cont_r;
  logic [4:0]  chan_r;
  logic [2:0]  div_r;
  logic        src_r;
  justify_t    just_r;
  logic [9:0]  res_r;
  logic        lock_r;

  // Conversion state
  conv_state_t state_r;
  logic [4:0]  cnt_r;
  logic        stab_r;
  logic        first_done_r;
  logic        xtal_prev_r;
  logic        src_tick;
  logic        done_evt;
  logic        done_valid;
  logic        post_evt;
  logic        sw_set;
  logic [4:0]  new_chan;
  logic        done_r;

  // Zero wait states keep the slave simple; every access answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = hrdata_r;

  assign acc     = hsel && htrans[1] && hready;
  assign rd_acc  = acc && !hwrite;
  assign acc_id  = decode(haddr[7:0]);
  assign wr_ctrl = wr_pend_r && (wr_id_r == REG_CTRL);
  assign wr_clk  = wr_pend_r && (wr_id_r == REG_CLK);
  assign rd_high = rd_acc && (acc_id == REG_RESH);
  assign rd_low  = rd_acc && (acc_id == REG_RESL);
  assign new_chan = hwdata[CS_CHAN_MSB:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_id_r   <= REG_NONE;
    end else begin
      wr_pend_r <= acc && hwrite;
      wr_id_r   <= acc_id;
    end
  end

  // Read data is taken in the address phase, so a read right behind a
  // write to the same register returns the value before that write.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (acc_id)
      REG_CTRL:
        rdata_nxt[7:0] = {flag_r, irq_en_r, cont_r, chan_r};
      REG_RESH: begin
        case (just_r)
          JUST_TRUNC8: rdata_nxt[7:0] = 8'h00;                // R15
          JUST_RIGHT:  rdata_nxt[7:0] = {6'h00, res_r[9:8]};  // R11
          JUST_LEFT:   rdata_nxt[7:0] = res_r[9:2];           // R10
          JUST_SIGNED: rdata_nxt[7:0] = {~res_r[9], res_r[8:2]}; // R12
          default:     rdata_nxt[7:0] = 8'h00;
        endcase
      end
      REG_RESL: begin
        case (just_r)
          JUST_TRUNC8: rdata_nxt[7:0] = res_r[9:2];           // R15
          JUST_RIGHT:  rdata_nxt[7:0] = res_r[7:0];           // R11
          JUST_LEFT:   rdata_nxt[7:0] = {res_r[1:0], 6'h00};  // R10
          JUST_SIGNED: rdata_nxt[7:0] = {res_r[1:0], 6'h00};  // R12
          default:     rdata_nxt[7:0] = 8'h00;
        endcase
      end
      REG_CLK:
        rdata_nxt[7:0] = {div_r, src_r, just_r, 2'b00};
      default:
        rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_acc) begin
      hrdata_r <= rdata_nxt;
    end
  end

  // Control fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_r <= CTRL_RESET[CS_IRQEN_BIT];               // R4
      cont_r   <= CTRL_RESET[CS_CONT_BIT];                // R5
      chan_r   <= CTRL_RESET[CS_CHAN_MSB:0];              // R7
    end else if (wr_ctrl) begin
      irq_en_r <= hwdata[CS_IRQEN_BIT];
      cont_r   <= hwdata[CS_CONT_BIT];
      chan_r   <= new_chan;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r  <= CLKCFG_RESET[CK_DIV_LSB +: 3];
      src_r  <= CLKCFG_RESET[CK_SRC_BIT];                 // R17
      just_r <= justify_t'(CLKCFG_RESET[CK_JUST_LSB +: 2]); // R18
    end else if (wr_clk) begin
      div_r  <= hwdata[CK_DIV_LSB +: 3];
      src_r  <= hwdata[CK_SRC_BIT];
      just_r <= justify_t'(hwdata[CK_JUST_LSB +: 2]);
    end
  end

  // Completion flag; a completion in the clearing cycle wins.
  assign sw_set   = wr_ctrl && irq_en_r && hwdata[CS_FLAG_BIT];    // R3
  assign post_evt = done_valid && (irq_en_r || !cont_r || !first_done_r); // R1

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_r <= CTRL_RESET[CS_FLAG_BIT];                  // R3
    end else if (post_evt || sw_set) begin
      flag_r <= 1'b1;                                     // R1
    end else if (wr_ctrl || rd_high || rd_low) begin
      flag_r <= 1'b0;                                     // R2
    end
  end

  assign conv_irq = irq_en_r && flag_r;                   // R4

  // Input clock selection and prescaler
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xtal_prev_r <= 1'b0;
    end else begin
      xtal_prev_r <= crystal_osc_clock;
    end
  end

  assign src_tick = src_r ? 1'b1 : (crystal_osc_clock && !xtal_prev_r); // R17

  conv_clock_div u_div (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .src_tick  (src_tick),
    .div_sel   (div_r),
    .conv_tick (conv_tick)
  );

  // Conversion sequencing
  assign done_evt   = (state_r == ST_CONV) && conv_tick &&
                      (cnt_r == CONV_CYCLES - 5'h01);     // R20
  assign done_valid = done_evt && !stab_r && !wr_ctrl;    // R8

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      cnt_r   <= 5'h00;
    end else if (wr_ctrl) begin
      cnt_r   <= 5'h00;                                   // R22
      state_r <= (new_chan == CHAN_OFF) ? ST_IDLE : ST_CONV; // R20
    end else begin
      case (state_r)
        ST_IDLE: begin
          cnt_r <= 5'h00;
        end
        ST_CONV: begin
          if (done_evt) begin
            cnt_r <= 5'h00;
            if (!cont_r && !stab_r) begin
              state_r <= ST_IDLE;                         // R5
            end
          end else if (conv_tick) begin
            cnt_r <= cnt_r + 5'h01;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          cnt_r   <= 5'h00;
        end
      endcase
    end
  end

  // The first conversion out of power-off only settles the analog part.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stab_r <= 1'b0;
    end else if (wr_ctrl) begin
      stab_r <= (chan_r == CHAN_OFF) && (new_chan != CHAN_OFF); // R8
    end else if (done_evt) begin
      stab_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_done_r <= 1'b0;
    end else if (wr_ctrl) begin
      first_done_r <= 1'b0;
    end else if (done_valid) begin
      first_done_r <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_r <= 1'b0;
    end else begin
      done_r <= done_valid;
    end
  end

  assign conv_done = done_r;

  // Result capture; unused channels simply pass whatever the core gives.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_r <= 10'h000;
    end else if (done_valid && !lock_r) begin
      res_r <= conv_data;                                 // R13 R21 R9
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_r <= 1'b0;
    end else if (just_r == JUST_TRUNC8) begin
      lock_r <= 1'b0;                                     // R15
    end else if (rd_high) begin
      lock_r <= 1'b1;                                     // R14
    end else if (rd_low) begin
      lock_r <= 1'b0;                                     // R14
    end
  end

  // Channel routing to the analog mux
  always_comb begin
    analog_inputs = 8'h00;
    if (chan_r < CHAN_PINS) begin
      analog_inputs[chan_r[2:0]] = 1'b1;                  // R6
    end
  end

  assign channel_select      = chan_r;
  assign ref_high            = (chan_r == CHAN_REFH);     // R6
  assign ref_low             = (chan_r == CHAN_REFL);     // R6
  assign converter_power_off = (chan_r == CHAN_OFF);      // R7
  assign conv_busy           = (state_r == ST_CONV);

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence start_s;
    wr_ctrl && (new_chan != CHAN_OFF);
  endsequence

  sequence first_tick_s;
    conv_busy && (cnt_r == 5'h00);
  endsequence

  power_off_idle_a: assert property ( // R7
    converter_power_off |-> !conv_busy && analog_inputs == 8'h00)
    else $error("converter active while powered off");

  start_conv_a: assert property ( // R20
    start_s |=> first_tick_s)
    else $error("control write did not start a conversion");

  done_count_a: assert property ( // R20
    done_valid |-> conv_tick && cnt_r == 5'h10 && conv_busy)
    else $error("conversion length wrong");

  write_clear_a: assert property ( // R2
    wr_ctrl && !sw_set && !post_evt |=> !flag_r)
    else $error("control write left flag set");

  read_clear_a: assert property ( // R2
    (rd_high || rd_low) && !post_evt && !sw_set |=> !flag_r && !conv_irq)
    else $error("result read left flag set");

  irq_raise_a: assert property ( // R4
    done_valid && irq_en_r && !wr_ctrl |=> conv_irq)
    else $error("no interrupt after conversion");

  single_stop_a: assert property ( // R5
    done_valid && !cont_r |=> !conv_busy ##1 (!conv_busy || $past(wr_ctrl)))
    else $error("single mode kept converting");

  stabilise_a: assert property ( // R8
    done_evt && stab_r |=> $stable(res_r) && !conv_done)
    else $error("settling conversion was posted");

  lock_hold_a: assert property ( // R14
    lock_r && done_valid |=> $stable(res_r))
    else $error("locked result overwritten");

  capture_a: assert property ( // R13
    done_valid && !lock_r |=> res_r == $past(conv_data) && conv_done)
    else $error("result not captured");

  trunc_high_a: assert property ( // R15
    rd_high && just_r == JUST_TRUNC8 |=> hrdata_r == 32'h0000_0000)
    else $error("high result nonzero in truncation mode");

  refh_sel_a: assert property ( // R6
    chan_r == CHAN_REFH |-> ref_high && !ref_low && analog_inputs == 8'h00)
    else $error("high reference not selected");

endmodule // adc_register_control

// ### rtl/conv_clock_div.sv
// Power-of-two prescaler making the converter clock tick.
// Assumes src_tick is a one-cycle pulse per selected input clock edge.
`timescale 1ns/10ps
module conv_clock_div
  import adc_pkg::*;
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Source and ratio
  input  wire logic       src_tick,
  input  wire logic [2:0] div_sel,
  // Divided tick
  output logic            conv_tick
);
  import adc_pkg::*;

  logic [3:0] cnt_r;
  logic [3:0] limit;
  logic [2:0] log_ratio;

  always_comb begin
    log_ratio = div_sel[2] ? DIV_MAX_LOG : div_sel; // R16
    limit     = 4'((5'h01 << log_ratio) - 5'h01);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r     <= 4'h0;
      conv_tick <= 1'b0;
    end else begin
      conv_tick <= 1'b0;
      if (src_tick) begin
        if (cnt_r >= limit) begin
          cnt_r     <= 4'h0;
          conv_tick <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end

endmodule // conv_clock_div
